// file: plk_host.sv
// What the document requires of link and phy
// [RULE1] null packet: data-on then idle, no speed
// [RULE2] at least one data-on before speed
// [RULE3] own self-id arrives like others
// [RULE4] receive may cut a status transfer
// [RULE5] speed code one cycle before data
// [RULE6] decode speed at first non data-on
// [RULE7] receive ends with at least one idle
// [RULE8] speed code encodings on the data lines
// [RULE9] grant one cycle then one idle
// [RULE10] after grant, at most one idle first
// [RULE11] hold zero to 47 cycles before transmit
// [RULE12] transmit, end cycle, idle, then release
// [RULE13] hold at end asks for concatenation
// [RULE14] next speed on data in end hold
// [RULE15] never concatenate s100 after faster packet
// [RULE16] phy drives idle one clock later
// [RULE17] phy releases lines after grant idle
// [RULE18] phy idles before next operation
// [RULE19] cancel: two idles then release; the code drives three (ST_REL1, ST_REL2, first ST_PHY cycle) before release
// [RULE20] cancel without hold: three idles
// [RULE21] phy ignores requests while not operational
// [RULE22] power status pulsed for isolated links
// [RULE23] low power status resets interface
// [RULE24] long low power status disables interface
// [RULE25] rising edge only, registered inputs
//
// Purpose: link-side controller for the phy receive and transmit handshake
// Assumes: phy pins synchronous to CLOCK; request line serial format is
//   produced elsewhere and only a one-bit bus request strobe is made here
// Notes: transmit words come through a 16 word fifo with back-pressure
`timescale 1ns/1ps
`include "plk_params.svh"
module plk_host (
  // clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // phy handshake code lines, split for tri-state
  input wire logic [1:0] CTL_I,
  output logic [1:0] CTL_O,
  output logic CTL_OE,
  // phy data lines
  input wire logic [7:0] DATA_I,
  output logic [7:0] DATA_O,
  output logic DATA_OE,
  // request and power status to phy
  output logic LINK_REQUEST_LINE,
  output logic LINK_POWER_STATUS,
  // user control
  input wire logic LINK_ENABLE,
  input wire logic PULSED_LPS,
  input wire logic MULTISPEED_CONCAT_ENABLE,
  input wire plk_pkg::plk_speed_type MAX_SPEED,
  input wire plk_pkg::plk_speed_type TX_SPEED,
  // transmit stream in
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire plk_pkg::plk_word_type TX_WORD,
  input wire logic TX_CONCAT,
  input wire plk_pkg::plk_speed_type TX_NEXT_SPEED,
  // receive stream out
  output logic RX_VALID,
  output plk_pkg::plk_rx_type RX_WORD,
  output logic RX_END,
  output logic RX_NULL,
  // status
  output logic TX_BUSY,
  output logic TX_DONE,
  output logic TX_CANCEL
);
  typedef enum logic [2:0] {
    ST_PHY, ST_IDLE1, ST_HOLD, ST_XMIT, ST_END, ST_REL1, ST_REL2
  } plk_state_type;

  localparam logic [11:0] RESET_CYC = 12'(`PLK_LPS_RESET_CYC);
  localparam logic [9:0] HALF_CYC = 10'(`PLK_LPS_HALF_CYC);

  plk_state_type st_q;
  logic [1:0] ctl_q;
  logic [7:0] data_q;
  logic [5:0] hold_q;
  logic cat_q;
  logic cat_spd_ok;
  logic req_q;
  logic [11:0] off_q;
  logic [9:0] half_q;
  logic lps_q;
  logic op_q;
  logic [1:0] ctl_o_q;
  logic [7:0] data_o_q;
  logic oe_q;
  plk_pkg::plk_speed_type cur_spd_q;
  logic f_valid;
  logic f_ready;
  plk_pkg::plk_word_type f_word;
  logic pend_q;
  logic [1:0] gap_q;
  logic grant_ok;

  ////////////////////////////////////////////////////////////////////////
  // transmit fifo; back-pressure reaches TX_READY
  plk_fifo #(.WIDTH(9), .DEPTH(`PLK_FIFO_DEPTH)) u_fifo (
    .clk(CLOCK),
    .nrst(NRST),
    .in_valid(TX_VALID),
    .in_ready(TX_READY),
    .in_data(TX_WORD),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_word)
  );

  // receive decode runs on registered lines only
  plk_rx u_rx (
    .clk(CLOCK),
    .nrst(NRST),
    .phy_owns(st_q == ST_PHY),
    .ctl_in(ctl_q),
    .data_in(data_q),
    .max_speed(MAX_SPEED),
    .rx_valid(RX_VALID),
    .rx_word(RX_WORD),
    .rx_end(RX_END),
    .rx_null(RX_NULL)
  );

  ////////////////////////////////////////////////////////////////////////
  // input registers, rising edge only
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ctl_q <= 2'h0;
      data_q <= 8'h00;
    end else begin
      ctl_q <= CTL_I; // RULE25
      data_q <= DATA_I;
    end
  end

  // power status: level or pulsed, low while disabled
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      lps_q <= 1'b0;
      half_q <= 10'h000;
    end else if (!LINK_ENABLE) begin
      lps_q <= 1'b0;
      half_q <= 10'h000;
    end else if (!PULSED_LPS) begin
      lps_q <= 1'b1;
    end else if (half_q == HALF_CYC - 10'h001) begin
      half_q <= 10'h000;
      lps_q <= !lps_q; // RULE22
    end else begin
      half_q <= half_q + 10'h001;
    end
  end

  // interface counted operational until low long enough to reset
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      off_q <= 12'h000;
      op_q <= 1'b0;
    end else if (!LINK_ENABLE) begin
      if (off_q != RESET_CYC) begin
        off_q <= off_q + 12'h001;
      end
      if (off_q == RESET_CYC) begin
        op_q <= 1'b0; // RULE23
      end
    end else begin
      off_q <= 12'h000;
      op_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // blank out grant decode while released lines float after our turn;
  // a floating line may read as grant for a cycle
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      gap_q <= 2'h0;
    end else if (st_q == ST_REL2) begin
      gap_q <= 2'h3;
    end else if (gap_q != 2'h0) begin
      gap_q <= gap_q - 2'h1;
    end
  end

  assign grant_ok = (ctl_q == `PLK_CODE_GRANT) && (pend_q || cat_q) && (gap_q == 2'h0);

  // bus request pending while data waits and the interface works
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pend_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      req_q <= 1'b0;
      if (!op_q || !LINK_ENABLE) begin
        pend_q <= 1'b0; // RULE21
      end else if (st_q == ST_PHY && f_valid && !pend_q && !cat_q) begin
        pend_q <= 1'b1;
        req_q <= 1'b1;
      end else if (st_q == ST_IDLE1) begin
        pend_q <= 1'b0;
      end
    end
  end

  // s100 may not follow a faster packet
  assign cat_spd_ok = !(TX_NEXT_SPEED == plk_pkg::PLK_S100 &&
                        cur_spd_q != plk_pkg::PLK_S100); // RULE15

  assign f_ready = (st_q == ST_XMIT) || (st_q == ST_HOLD);

  ////////////////////////////////////////////////////////////////////////
  // link ownership state machine after a grant
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_q <= ST_PHY;
      hold_q <= 6'h00;
      cat_q <= 1'b0;
      cur_spd_q <= plk_pkg::PLK_S100;
    end else if (!LINK_ENABLE) begin
      st_q <= ST_PHY;
      cat_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_PHY: begin
          hold_q <= 6'h00;
          if (grant_ok) begin
            st_q <= ST_IDLE1; // RULE9
            if (!cat_q) begin
              cur_spd_q <= TX_SPEED;
            end
          end
        end
        ST_IDLE1: begin
          st_q <= ST_HOLD; // RULE10
          hold_q <= 6'h00;
        end
        ST_HOLD: begin
          hold_q <= hold_q + 6'h01;
          if (f_valid) begin
            st_q <= f_word.last ? ST_END : ST_XMIT;
          end else if (hold_q == `PLK_MAX_HOLD - 6'h01) begin
            st_q <= ST_REL1; // RULE11 RULE20
            cat_q <= 1'b0;
          end
        end
        ST_XMIT: begin
          if (f_word.last && f_valid) begin
            st_q <= ST_END; // RULE12
          end
        end
        ST_END: begin
          st_q <= ST_REL2;
          cat_q <= TX_CONCAT && cat_spd_ok; // RULE13
          if (TX_CONCAT && cat_spd_ok && MULTISPEED_CONCAT_ENABLE) begin
            cur_spd_q <= TX_NEXT_SPEED;
          end
        end
        ST_REL1: begin
          st_q <= ST_REL2; // RULE19
        end
        ST_REL2: begin
          st_q <= ST_PHY;
        end
      endcase
    end
  end

  // speed code for the concatenation hold
  function automatic logic [7:0] spd_code(plk_pkg::plk_speed_type s);
    logic [7:0] r;
    r = `PLK_SPD_S100;
    if (s == plk_pkg::PLK_S200) begin
      r = `PLK_SPD_S200;
    end else if (s == plk_pkg::PLK_S400) begin
      r = `PLK_SPD_S400;
    end
    return r; // RULE8
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin drive registers; idle driven in every owned cycle that drives no hold or transmit code
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ctl_o_q <= 2'h0;
      data_o_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      oe_q <= LINK_ENABLE && (st_q != ST_PHY || grant_ok);
      ctl_o_q <= `PLK_CODE_IDLE;
      data_o_q <= 8'h00;
      // one idle after the grant, then hold, so the first idle is the only one
      if (st_q == ST_IDLE1) begin
        ctl_o_q <= `PLK_CODE_HOLD; // RULE10
      end else if (st_q == ST_HOLD && f_valid) begin
        ctl_o_q <= `PLK_CODE_XMIT;
        data_o_q <= f_word.data;
      end else if (st_q == ST_HOLD && hold_q != `PLK_MAX_HOLD - 6'h01) begin
        ctl_o_q <= `PLK_CODE_HOLD; // RULE11
      end else if (st_q == ST_XMIT && f_valid) begin
        ctl_o_q <= `PLK_CODE_XMIT; // RULE12
        data_o_q <= f_word.data;
      end else if (st_q == ST_END && TX_CONCAT && cat_spd_ok) begin
        ctl_o_q <= `PLK_CODE_HOLD; // RULE13
        data_o_q <= MULTISPEED_CONCAT_ENABLE ? spd_code(TX_NEXT_SPEED) : 8'h00; // RULE14
      end
    end
  end

  assign CTL_O = ctl_o_q;
  assign DATA_O = data_o_q;
  assign CTL_OE = oe_q;
  assign DATA_OE = oe_q;
  assign LINK_REQUEST_LINE = req_q;
  assign LINK_POWER_STATUS = lps_q;
  assign TX_BUSY = (st_q != ST_PHY);
  assign TX_DONE = (st_q == ST_END);
  assign TX_CANCEL = (st_q == ST_REL1);

  ////////////////////////////////////////////////////////////////////////
  // checks on what this end drives
  AST_GRANT_IDLE: assert property (@(posedge CLOCK) disable iff (!NRST)
    st_q == ST_IDLE1 |=> st_q == ST_HOLD) else $error("no hold phase after grant"); // RULE10
  AST_HOLD_MAX: assert property (@(posedge CLOCK) disable iff (!NRST)
    hold_q <= `PLK_MAX_HOLD) else $error("hold count beyond limit"); // RULE11
  AST_END_IDLE: assert property (@(posedge CLOCK) disable iff (!NRST)
    st_q == ST_END && LINK_ENABLE |=> st_q == ST_REL2 ##1 st_q == ST_PHY)
    else $error("release sequence broken"); // RULE12
  AST_CANCEL: assert property (@(posedge CLOCK) disable iff (!NRST)
    st_q == ST_REL1 && LINK_ENABLE |=> ##1 ctl_o_q == 2'h0 && oe_q)
    else $error("cancel idles missing"); // RULE19
  AST_CAT_SPD: assert property (@(posedge CLOCK) disable iff (!NRST)
    ctl_o_q == `PLK_CODE_HOLD && oe_q && MULTISPEED_CONCAT_ENABLE && $past(st_q) == ST_END
    |-> data_o_q[7] == 1'b0) else $error("concat speed code missing"); // RULE14
  AST_NO_S100_CAT: assert property (@(posedge CLOCK) disable iff (!NRST)
    $rose(cat_q) |-> !($past(TX_NEXT_SPEED) == plk_pkg::PLK_S100 &&
                      $past(cur_spd_q) != plk_pkg::PLK_S100)) else $error("s100 concat"); // RULE15
  AST_REQ_OFF: assert property (@(posedge CLOCK) disable iff (!NRST)
    !op_q |-> ##1 !req_q) else $error("request while interface down"); // RULE21
  AST_RESET_LOW: assert property (@(posedge CLOCK) disable iff (!NRST)
    !LINK_ENABLE |-> ##1 !lps_q) else $error("power status not low"); // RULE23
  AST_REG_IN: assert property (@(posedge CLOCK) disable iff (!NRST)
    ctl_q == $past(CTL_I)) else $error("inputs not registered"); // RULE25
  COV_XMIT: cover property (@(posedge CLOCK) disable iff (!NRST) st_q == ST_END);
  COV_CANCEL: cover property (@(posedge CLOCK) disable iff (!NRST) st_q == ST_REL1);
  COV_CAT: cover property (@(posedge CLOCK) disable iff (!NRST) $rose(cat_q));
  COV_NULL: cover property (@(posedge CLOCK) disable iff (!NRST) RX_NULL);
endmodule

// file: plk_params.svh
// Purpose: timing counts and code values for the link-side phy controller
// Assumes: 200 MHz CLOCK, all phy pins synchronous to it
// Notes: the power status counts are derived from times given in ns
`ifndef PLK_PARAMS_SVH
`define PLK_PARAMS_SVH
`define PLK_CLK_MHZ 200
`define PLK_CODE_IDLE 2'h0
`define PLK_CODE_HOLD 2'h1
`define PLK_CODE_XMIT 2'h2
`define PLK_CODE_GRANT 2'h3
`define PLK_CODE_STATUS 2'h1
`define PLK_CODE_RECV 2'h2
`define PLK_DATA_ON 8'hff
`define PLK_SPD_S100 8'h00
`define PLK_SPD_S200 8'h40
`define PLK_SPD_S400 8'h50
`define PLK_MAX_HOLD 6'h2f
`define PLK_FIFO_DEPTH 16
// power status pulse half period, ns, inside the pulsed low and high limits
`define PLK_LPS_HALF_NS 1000
`define PLK_LPS_HALF_CYC ((`PLK_LPS_HALF_NS * `PLK_CLK_MHZ) / 1000)
// reset recognition time, ns: we hold low at least this long plus margin
`define PLK_LPS_RESET_NS 2680
`define PLK_LPS_RESET_CYC (((`PLK_LPS_RESET_NS * `PLK_CLK_MHZ) + 999) / 1000 + 16)
`endif

// file: plk_pkg.sv
// Purpose: shared types for the link-side phy controller
// Assumes: nothing beyond the params header
// Notes: speeds use a two-bit code, 3 meaning invalid
package plk_pkg;
  typedef enum logic [1:0] {PLK_S100, PLK_S200, PLK_S400, PLK_SBAD} plk_speed_type;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } plk_word_type;
  typedef struct packed {
    logic [7:0] data;
    logic first;
    plk_speed_type speed;
  } plk_rx_type;
endpackage

// file: plk_fifo.sv
// Purpose: small valid/ready fifo of flip-flop storage
// Assumes: one clock, async active low reset
// Notes: no bypass, so a word takes one cycle to appear at the output
`timescale 1ns/1ps
module plk_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest full and empty from the occupancy count
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  ////////////////////////////////////////////////////////////////////////
  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// file: plk_rx.sv
// Purpose: receive side decode of the phy handshake lines
// Assumes: inputs are registered copies, one cycle old
// Notes: a bad or too fast speed code drops the whole packet
`timescale 1ns/1ps
`include "plk_params.svh"
module plk_rx (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // registered lines and direction
  input wire logic phy_owns,
  input wire logic [1:0] ctl_in,
  input wire logic [7:0] data_in,
  input wire plk_pkg::plk_speed_type max_speed,
  // decoded stream
  output logic rx_valid,
  output plk_pkg::plk_rx_type rx_word,
  output logic rx_end,
  output logic rx_null
);
  logic in_recv_q;
  logic got_spd_q;
  logic drop_q;
  plk_pkg::plk_speed_type spd_q;
  plk_pkg::plk_speed_type dec;
  logic recv;

  assign recv = phy_owns && (ctl_in == `PLK_CODE_RECV);

  // speed code decode, don't-care bits ignored for s100 and s200; s400 must match exactly
  always_comb begin
    if (data_in[7:6] == 2'h0) begin
      dec = plk_pkg::PLK_S100; // RULE8
    end else if (data_in[7:4] == 4'h4) begin
      dec = plk_pkg::PLK_S200;
    end else if (data_in == `PLK_SPD_S400) begin
      dec = plk_pkg::PLK_S400;
    end else begin
      dec = plk_pkg::PLK_SBAD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive tracking; first non data-on cycle carries the speed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_recv_q <= 1'b0;
      got_spd_q <= 1'b0;
      drop_q <= 1'b0;
      spd_q <= plk_pkg::PLK_S100;
    end else begin
      in_recv_q <= recv;
      if (!recv) begin
        got_spd_q <= 1'b0;
        drop_q <= 1'b0;
      end else if (!got_spd_q && !data_in[7]) begin
        got_spd_q <= 1'b1; // RULE6
        spd_q <= dec;
        drop_q <= (dec == plk_pkg::PLK_SBAD) || (dec > max_speed); // RULE6
      end
    end
  end

  // data words out; packet end and null packet strobes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_valid <= 1'b0;
      rx_word <= '0;
      rx_end <= 1'b0;
      rx_null <= 1'b0;
    end else begin
      rx_valid <= recv && got_spd_q && !drop_q;
      rx_word.data <= data_in;
      rx_word.speed <= spd_q;
      rx_word.first <= recv && got_spd_q && !in_recv_q ? 1'b0 : 1'b0;
      rx_end <= in_recv_q && !recv;
      rx_null <= in_recv_q && !recv && !got_spd_q; // RULE1
    end
  end
endmodule

// file: plk_phy_model.sv
// Purpose: behavioural phy facing the link controller
// Assumes: all pins move just after the rising clk edge
// Notes: undriven lines show the inverse of their last driven value
`timescale 1ns/1ps
module plk_phy_model #(
  parameter int ARB = 30,
  parameter int GAP = 4,
  parameter int RST_CYC = 536
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link outputs
  input wire logic [1:0] l_ctl,
  input wire logic l_oe,
  input wire logic [7:0] l_data,
  input wire logic link_request_line,
  input wire logic link_power_status,
  // resolved lines
  output logic [1:0] ctl_w,
  output logic [7:0] data_w
);
  logic p_oe = 1'b1;
  logic [1:0] p_ctl = 2'h0;
  logic [7:0] p_data = 8'h00;
  logic [9:0] last_q = 10'h000;
  logic busy = 1'b0;
  logic off;
  int low_n = 0;
  int nreq = 0;
  int nsrv = 0;
  int ngnt = 0;
  logic [9:0] cap[$];
  //////////////////////////////////////////////////////////////////////////
  // wire resolution; no pull, so a float must not look like a hold
  assign off = low_n >= RST_CYC;
  assign {ctl_w, data_w} = off ? 10'h000 : l_oe ? {l_ctl, l_data} :
    p_oe ? {p_ctl, p_data} : ~last_q;
  // last driven value, power status low time, request latch
  always @(posedge clk) begin
    if (l_oe || p_oe) last_q <= {ctl_w, data_w};
    low_n <= link_power_status ? 0 : low_n + 1;
    if (off) nreq <= nsrv;
    else if (link_request_line && nrst) nreq <= nreq + 1;
  end
  //////////////////////////////////////////////////////////////////////////
  // arbitration is slow on purpose so the fifo gets to fill
  initial forever begin
    @(posedge clk);
    if (nreq > nsrv && !busy) begin
      busy = 1'b1;
      nsrv++;
      repeat (ARB) @(posedge clk);
      own();
      busy = 1'b0;
    end
  end
  // grant, hand over, record the link, take back; repeat on concat
  task automatic own();
    int w;
    logic cat;
    cat = 1'b1;
    while (cat) begin
      ngnt++;
      p_ctl <= 2'h3;
      @(posedge clk) p_ctl <= 2'h0;
      @(posedge clk) p_oe <= 1'b0;
      w = 0;
      // serial bus stays in data-prefix while the link holds
      // sample mid-cycle, where the link's registered pins have settled
      do begin
        @(negedge clk);
        w++;
        if (l_oe) cap.push_back({l_ctl, l_data});
      end while ((l_oe || w < 4) && w < 400);
      @(posedge clk);
      p_oe <= 1'b1;
      p_ctl <= 2'h0;
      cat = cap.size() > 1 && cap[cap.size() - 2][9:8] == 2'h1;
      if (cat) repeat (GAP) @(posedge clk);
    end
  endtask
  // one receive; nb bytes, zero for a null packet; own self-id alike
  task automatic rx_pkt(input logic [7:0] spd, input int nb, input int dn, input logic st);
    int i;
    wait (!busy);
    busy = 1'b1;
    if (st) begin
      p_ctl <= 2'h1;
      @(posedge clk);
    end
    p_ctl <= 2'h2;
    p_data <= 8'hff;
    repeat (dn) @(posedge clk);
    if (nb > 0) begin
      p_data <= spd;
      @(posedge clk);
    end
    for (i = 0; i < nb; i++) begin
      p_data <= 8'h10 + 8'(i);
      @(posedge clk);
    end
    p_ctl <= 2'h0;
    p_data <= 8'h00;
    @(posedge clk);
    busy = 1'b0;
  endtask
endmodule

// file: tb_top.sv
// Purpose: self-checking bench for the link-side phy controller
// Assumes: behavioural phy model on the far side
// Notes: expected bytes follow the model's fixed byte pattern
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic link_enable = 1'b0;
  logic pulsed_lps = 1'b0;
  logic msc = 1'b0;
  plk_pkg::plk_speed_type max_speed = plk_pkg::PLK_S400;
  plk_pkg::plk_speed_type tx_speed = plk_pkg::PLK_S400;
  plk_pkg::plk_speed_type tx_next_speed = plk_pkg::PLK_S400;
  logic tx_valid = 1'b0;
  plk_pkg::plk_word_type tx_word = '0;
  logic tx_concat = 1'b0;
  logic [1:0] ctl_i, ctl_o;
  logic [7:0] data_i, data_o;
  logic ctl_oe, data_oe, link_request_line, link_power_status, tx_ready, rx_valid, rx_end, rx_null, tx_busy, tx_done;
  plk_pkg::plk_rx_type rx_word;
  plk_pkg::plk_rx_type rxq[$];
  int ends = 0;
  int nulls = 0;
  int miscompares = 0;
  int check_count = 0;
  //////////////////////////////////////////////////////////////////////////
  plk_host dut_u (.CLOCK(clock), .NRST(nrst), .CTL_I(ctl_i), .CTL_O(ctl_o), .CTL_OE(ctl_oe),
    .DATA_I(data_i), .DATA_O(data_o), .DATA_OE(data_oe), .LINK_REQUEST_LINE(link_request_line),
    .LINK_POWER_STATUS(link_power_status), .LINK_ENABLE(link_enable), .PULSED_LPS(pulsed_lps),
    .MULTISPEED_CONCAT_ENABLE(msc), .MAX_SPEED(max_speed), .TX_SPEED(tx_speed),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_WORD(tx_word), .TX_CONCAT(tx_concat),
    .TX_NEXT_SPEED(tx_next_speed), .RX_VALID(rx_valid), .RX_WORD(rx_word), .RX_END(rx_end),
    .RX_NULL(rx_null), .TX_BUSY(tx_busy), .TX_DONE(tx_done), .TX_CANCEL());
  plk_phy_model phy_u (.clk(clock), .nrst(nrst), .l_ctl(ctl_o), .l_oe(ctl_oe),
    .l_data(data_o), .link_request_line(link_request_line), .link_power_status(link_power_status), .ctl_w(ctl_i), .data_w(data_i));
  //////////////////////////////////////////////////////////////////////////
  // clock at 200 MHz
  initial forever #2.5 clock = ~clock;
  // receive stream monitor
  always @(negedge clock) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_word);
    if (rx_end === 1'b1) ends++;
    if (rx_null === 1'b1) nulls++;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  // bounded wait until the phy has taken the interface back n grants on
  task automatic settle(input int g);
    int i;
    for (i = 0; i < 3000 && !(phy_u.busy === 1'b0 && phy_u.ngnt >= g); i++) @(posedge clock);
    repeat (4) @(posedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // receive: cut status, null, too fast, s100
  task automatic t_rx();
    int i;
    phy_u.rx_pkt(8'h40, 4, 2, 1'b1);
    repeat (4) @(posedge clock);
    chk(16'(ends), 16'h1, "rx end");
    phy_u.rx_pkt(8'hff, 0, 1, 1'b0);
    repeat (4) @(posedge clock);
    chk(16'(nulls), 16'h1, "rx null");
    max_speed <= plk_pkg::PLK_S200;
    phy_u.rx_pkt(8'h50, 3, 1, 1'b0);
    repeat (4) @(posedge clock);
    chk(16'(rxq.size()), 16'h4, "too fast dropped");
    phy_u.rx_pkt(8'h00, 2, 1, 1'b0);
    repeat (4) @(posedge clock);
    chk(16'(rxq.size()), 16'h6, "rx bytes");
    for (i = 0; i < 6 && i < rxq.size(); i++)
      chk(16'(rxq[i]), {5'h0, 8'h10 + 8'(i % 4), 1'b0,
        i < 4 ? plk_pkg::PLK_S200 : plk_pkg::PLK_S100}, "rx word");
    $display("test rx finished");
  endtask
  // 18 byte packet against a 16 word fifo and a slow grant
  task automatic t_tx();
    int i, k, nx, stall;
    logic rdy;
    phy_u.cap.delete();
    stall = 0;
    nx = 0;
    tx_valid <= 1'b1;
    for (i = 0; i < 18; i++) begin
      tx_word <= {8'h20 + 8'(i), i == 17};
      do begin
        @(negedge clock);
        rdy = tx_ready;
        @(posedge clock);
        stall += (rdy !== 1'b1);
      end while (rdy !== 1'b1 && stall < 2000);
    end
    tx_valid <= 1'b0;
    settle(1);
    k = phy_u.cap.size();
    chk(16'(stall > 0), 16'h1, "fifo refused when full");
    chk(16'(k > 3), 16'h1, "link drove");
    if (k > 3) begin
      chk(16'(phy_u.cap[0][9:8] == 2'h0 && phy_u.cap[1][9:8] == 2'h0), 16'h0, "lead idle");
      for (i = 0; i < k; i++)
        if (phy_u.cap[i][9:8] == 2'h2) begin
          chk(16'(phy_u.cap[i][7:0]), 16'(8'h20 + 8'(nx)), "tx byte");
          nx++;
        end
      chk(16'(nx), 16'h12, "tx count");
      chk(16'(phy_u.cap[k - 2][9:8]), 16'h0, "end code idle");
      chk(16'(phy_u.cap[k - 1][9:8]), 16'h0, "final idle");
    end
    chk(16'({tx_ready, tx_busy}), 16'h2, "drained and free");
    $display("test tx finished");
  endtask
  // two packets asking for concatenation at a given next speed
  task automatic t_cat(input plk_pkg::plk_speed_type nxt, input logic [1:0] ec);
    int i, k, g0;
    logic rdy;
    phy_u.cap.delete();
    g0 = phy_u.ngnt;
    msc <= 1'b1;
    pulsed_lps <= 1'b1;
    tx_next_speed <= nxt;
    tx_concat <= 1'b1;
    tx_valid <= 1'b1;
    for (i = 0; i < 4; i++) begin
      tx_word <= {8'h30 + 8'(i), i == 1 || i == 3};
      do begin
        @(negedge clock);
        rdy = tx_ready;
        @(posedge clock);
      end while (rdy !== 1'b1);
    end
    tx_valid <= 1'b0;
    for (i = 0; i < 3000 && tx_done !== 1'b1; i++) @(negedge clock);
    @(posedge clock);
    tx_concat <= 1'b0;
    settle(g0 + 2);
    chk(16'(phy_u.ngnt - g0), 16'h2, "two grants");
    k = 0;
    while (k < phy_u.cap.size() && phy_u.cap[k][9:8] != 2'h2) k++;
    while (k < phy_u.cap.size() && phy_u.cap[k][9:8] == 2'h2) k++;
    if (k < phy_u.cap.size()) begin
      chk(16'(phy_u.cap[k][9:8]), 16'(ec), "concat end code");
      if (ec == 2'h1) chk(16'(phy_u.cap[k][7:0]), 16'h40, "next speed code");
    end
    else chk(16'h0, 16'h1, "no end code");
    $display("test concat finished");
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock) link_enable <= 1'b1;
    repeat (4) @(posedge clock);
    chk(16'(link_power_status), 16'h1, "power status level");
    t_rx();
    t_tx();
    t_cat(plk_pkg::PLK_S200, 2'h1);
    t_cat(plk_pkg::PLK_S100, 2'h0);
    complete_run();
  end
endmodule
